// ---- src/ahrs_pkg.sv ----
// Register map, field layout, states and timing constants of the axis home return sequencer.
package ahrs_pkg;
  localparam int AXES         = 2;
  localparam int AW           = 8;
  localparam int PW           = 32;
  localparam int SPW          = 16;
  localparam int AXIS_SEL_BIT = 6;

  // Word offsets inside one axis window; the axis window is picked by paddr[AXIS_SEL_BIT].
  localparam logic [5:0] REG_CTRL     = 6'h00;
  localparam logic [5:0] REG_CFG      = 6'h04;
  localparam logic [5:0] REG_HOME_ADR = 6'h08;
  localparam logic [5:0] REG_HOME_SPD = 6'h0C;
  localparam logic [5:0] REG_CREEP    = 6'h10;
  localparam logic [5:0] REG_DWELL    = 6'h14;
  localparam logic [5:0] REG_POST_DOG = 6'h18;
  localparam logic [5:0] REG_STATUS   = 6'h1C;
  localparam logic [5:0] REG_CUR_FEED = 6'h20;
  localparam logic [5:0] REG_MACH     = 6'h24;
  localparam logic [5:0] REG_HOME_ABS = 6'h28;

  // Control word: return kind and auxiliary function requests.
  localparam int         CTRL_KIND_LSB  = 0;
  localparam logic [1:0] KIND_NONE      = 2'h0;
  localparam logic [1:0] KIND_MACHINE   = 2'h1;
  localparam int         CTRL_RETRY_BIT = 2;
  localparam int         CTRL_SHIFT_BIT = 3;
  // Configuration word.
  localparam int CFG_METHOD_LSB = 0;
  localparam int CFG_DIR_BIT    = 4;
  // Status word.
  localparam int ST_REQ_BIT   = 0;
  localparam int ST_DONE_BIT  = 1;
  localparam int ST_BUSY_BIT  = 2;
  localparam int ST_REJ_BIT   = 3;
  localparam int ST_STATE_LSB = 8;

  // Reset values.
  localparam logic [SPW-1:0] RST_HOME_SPD = 16'h0010;
  localparam logic [SPW-1:0] RST_CREEP    = 16'h0040;
  localparam logic [SPW-1:0] RST_DWELL    = 16'h0000;
  localparam logic [PW-1:0]  RST_ADDR     = 32'h0000_0000;
  localparam logic [PW-1:0]  RST_POST_DOG = 32'h0000_0000;
  localparam logic           RST_REQ      = 1'b1;

  // Timing: the dwell setting counts milliseconds; the deviation clear output is held for DEVCLR_CYC - 1 clock cycles.
  localparam int CLK_PERIOD_NS = 10;
  localparam int DWELL_UNIT_NS = 1_000_000;
  localparam int DEVCLR_NS     = 10_000;
  localparam int DEVCLR_CYC    = (DEVCLR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    M_DOG   = 3'h0,
    M_STOP1 = 3'h1,
    M_STOP2 = 3'h2,
    M_STOP3 = 3'h3,
    M_CNT1  = 3'h4,
    M_CNT2  = 3'h5
  } ahrs_method_t;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_FAST   = 3'b001,
    ST_CREEP  = 3'b011,
    ST_DWELL  = 3'b010,
    ST_TRAVEL = 3'b110,
    ST_SEEK   = 3'b111,
    ST_CLEAR  = 3'b101,
    ST_DONE   = 3'b100
  } ahrs_state_t;

  typedef struct packed {
    ahrs_method_t     method;
    logic             dir_neg;
    logic [PW-1:0]    home_addr;
    logic [SPW-1:0]   home_spd;
    logic [SPW-1:0]   creep_spd;
    logic [SPW-1:0]   dwell_ms;
    logic [PW-1:0]    post_dog;
  } ahrs_cfg_t;

  // State taken once the dog has been seen, or at once when the start lands on the dog.
  function automatic ahrs_state_t ahrs_after_dog(input ahrs_method_t m);
    ahrs_state_t s;
    s = ST_CREEP;
    if (m == M_STOP1)
      s = ST_DWELL;
    else if (m == M_CNT1 || m == M_CNT2)
      s = ST_TRAVEL;
    return s;
  endfunction
endpackage

// ---- src/ahrs_top.sv ----
// Two-axis machine home return sequencer with its APB register slave.
//
// Behaviour
// - A drive ready falling edge sets that axis's home return request flag.
// - The station ready rising edge sets the request flag of every axis.
// - Normal completion clears the request flag and sets the complete flag.
// - Shift and retry go with machine return only; other return kinds are rejected.
// - Homing uses no held address; the reached stop becomes the new origin.
// - Motion runs at configured speed and direction, stopping where the method finds home.
// - At home, the home address loads the current and machine feed monitors.
// - Home absolute monitor gets the home address and follows address changes.
// - The method setting selects dog, stopper one to three, or count one and two.
// - Dog: creep at dog rise, stop at first marker after dog falls, then clear.
// - Stopper one: creep at dog rise, finish with clear after the dwell time.
// - Stopper two: creep at dog rise, finish with clear after stopper contact.
// - Stopper three: creep from the start, finish with clear on stopper contact.
// - Count one: travel post-dog distance at creep, then stop at next marker, clear.
// - Count two: stop after the post-dog distance and complete with no marker.
// - At the home stop, pulses halt and then deviation clear goes to the drive; count two completes with no clear.
// - A start with the dog already on begins directly at creep speed.
`timescale 1ns/1ps
module ahrs_top
  import ahrs_pkg::*;
#(
  parameter int MS_CYCLES = DWELL_UNIT_NS / CLK_PERIOD_NS
)
(
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [AW-1:0]   paddr,
  input  wire logic [31:0]     pwdata,
  output logic      [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr,
  input  wire logic [AXES-1:0] drive_ready,
  input  wire logic            station_ready,
  input  wire logic [AXES-1:0] near_dog,
  input  wire logic [AXES-1:0] home_marker,
  output logic      [AXES-1:0] feed_pulse,
  output logic      [AXES-1:0] feed_dir,
  output logic      [AXES-1:0] dev_clear
);
  localparam int MSW = $clog2(MS_CYCLES + 1);
  localparam int DCW = $clog2(DEVCLR_CYC + 1);
  localparam logic [MSW-1:0] MS_LAST = MSW'(MS_CYCLES - 1);
  localparam logic [DCW-1:0] DC_LAST = DCW'(DEVCLR_CYC - 1);

  logic                 pready_r;
  logic                 pslverr_r;
  logic [31:0]          prdata_r;
  logic                 stn_q_r;
  logic [AXES-1:0][31:0] rd_word;

  wire logic       setup    = psel && !penable;
  wire logic [5:0] offs     = paddr[5:0];
  wire logic       axis_sel = paddr[AXIS_SEL_BIT];
  wire logic       bad_addr = (paddr[AW-1:AXIS_SEL_BIT+1] != '0) || (offs > REG_HOME_ABS) || (offs[1:0] != 2'h0);
  wire logic       wr_en    = psel && penable && pready_r && pwrite && !pslverr_r;
  wire logic       stn_rise = station_ready && !stn_q_r;

  // Zero-wait slave: the answer is prepared in the setup cycle and shown for the single access cycle.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end
    else
    begin
      pready_r  <= setup;
      pslverr_r <= setup && bad_addr;
      if (setup)
        prdata_r <= (bad_addr || pwrite) ? 32'h0000_0000 : rd_word[axis_sel];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      stn_q_r <= 1'b0;
    else
      stn_q_r <= station_ready;
  end

  assign pready  = pready_r;
  assign pslverr = pslverr_r;
  assign prdata  = prdata_r;

  for (genvar a = 0; a < AXES; a++)
  begin : g_axis
    ahrs_cfg_t      cfg_r;
    ahrs_state_t    st_r;
    logic           req_r;
    logic           done_r;
    logic           rej_r;
    logic           dog_q_r;
    logic           drdy_q_r;
    logic           pulse_r;
    logic           clr_r;
    logic [SPW-1:0] pdiv_r;
    logic [SPW-1:0] dwell_r;
    logic [MSW-1:0] ms_r;
    logic [DCW-1:0] clk_cnt_r;
    logic [PW-1:0]  cur_r;
    logic [PW-1:0]  mach_r;
    logic [PW-1:0]  habs_r;
    logic [PW-1:0]  trav_r;
    logic [31:0]    rd_local;

    wire logic       wr       = wr_en && (axis_sel == 1'(a));
    wire logic       idle     = (st_r == ST_IDLE);
    wire logic [1:0] kind     = pwdata[CTRL_KIND_LSB +: 2];
    wire logic       ctrl_wr  = wr && (offs == REG_CTRL) && (kind != KIND_NONE);
    wire logic       meth_ok  = (cfg_r.method <= M_CNT2);
    wire logic       start    = ctrl_wr && idle && (kind == KIND_MACHINE) && meth_ok;
    wire logic       dog_rise = near_dog[a] && !dog_q_r;
    wire logic       dog_fall = !near_dog[a] && dog_q_r;
    wire logic       drdy_off = !drive_ready[a] && drdy_q_r;
    wire logic       moving   = !idle && (st_r != ST_CLEAR) && (st_r != ST_DONE);
    wire logic       dwell_ok = (dwell_r >= cfg_r.dwell_ms);
    wire logic       trav_ok  = (trav_r >= cfg_r.post_dog);
    wire logic [SPW-1:0] period = (st_r == ST_FAST) ? cfg_r.home_spd : cfg_r.creep_spd;

    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        dog_q_r  <= 1'b0;
        drdy_q_r <= 1'b0;
      end
      else
      begin
        dog_q_r  <= near_dog[a];
        drdy_q_r <= drive_ready[a];
      end
    end

    // Settings are frozen while a return runs so a half-applied change cannot steer it.
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        cfg_r.method    <= M_DOG;
        cfg_r.dir_neg   <= 1'b0;
        cfg_r.home_addr <= RST_ADDR;
        cfg_r.home_spd  <= RST_HOME_SPD;
        cfg_r.creep_spd <= RST_CREEP;
        cfg_r.dwell_ms  <= RST_DWELL;
        cfg_r.post_dog  <= RST_POST_DOG;
      end
      else if (wr && idle)
      begin
        case (offs)
          REG_CFG:
          begin
            cfg_r.method  <= ahrs_method_t'(pwdata[CFG_METHOD_LSB +: 3]);
            cfg_r.dir_neg <= pwdata[CFG_DIR_BIT];
          end
          REG_HOME_ADR: cfg_r.home_addr <= pwdata;
          REG_HOME_SPD: cfg_r.home_spd  <= pwdata[SPW-1:0];
          REG_CREEP:    cfg_r.creep_spd <= pwdata[SPW-1:0];
          REG_DWELL:    cfg_r.dwell_ms  <= pwdata[SPW-1:0];
          REG_POST_DOG: cfg_r.post_dog  <= pwdata;
          default:      cfg_r.method    <= cfg_r.method;
        endcase
      end
    end

    // Sequencer; the speed and direction of each phase come from the settings.
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        st_r      <= ST_IDLE;
        clr_r     <= 1'b0;
        clk_cnt_r <= '0;
      end
      else
      begin
        case (st_r)
          ST_IDLE:
            if (start)
            begin
              if (cfg_r.method == M_STOP3)
                st_r <= ST_CREEP;
              else if (near_dog[a])
                st_r <= ahrs_after_dog(cfg_r.method);
              else
                st_r <= ST_FAST;
            end
          ST_FAST:
            if (dog_rise)
              st_r <= ahrs_after_dog(cfg_r.method);
          ST_CREEP:
            if (cfg_r.method == M_DOG && dog_fall)
              st_r <= ST_SEEK;
            else if (cfg_r.method != M_DOG && home_marker[a])
              st_r <= ST_CLEAR;
          ST_DWELL:
            if (dwell_ok)
              st_r <= ST_CLEAR;
          ST_TRAVEL:
            if (trav_ok)
              st_r <= (cfg_r.method == M_CNT2) ? ST_DONE : ST_SEEK;
          ST_SEEK:
            if (home_marker[a])
              st_r <= ST_CLEAR;
          ST_CLEAR:
            if (clk_cnt_r == DC_LAST)
              st_r <= ST_DONE;
          ST_DONE:
            st_r <= ST_IDLE;
          default:
            st_r <= ST_IDLE;
        endcase
        // Pulses have already stopped in the clear phase, so the drive clears a settled deviation.
        clr_r     <= (st_r == ST_CLEAR) && (clk_cnt_r != DC_LAST);
        clk_cnt_r <= (st_r == ST_CLEAR) ? clk_cnt_r + DCW'(1) : '0;
      end
    end

    // Pulse train: one pulse per period setting, period read afresh at each pulse.
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        pulse_r <= 1'b0;
        pdiv_r  <= '0;
      end
      else if (!moving)
      begin
        pulse_r <= 1'b0;
        pdiv_r  <= '0;
      end
      else if (pdiv_r == '0)
      begin
        pulse_r <= 1'b1;
        pdiv_r  <= (period == '0) ? '0 : period - SPW'(1);
      end
      else
      begin
        pulse_r <= 1'b0;
        pdiv_r  <= pdiv_r - SPW'(1);
      end
    end

    // Dwell is timed in milliseconds from entry to the dwell phase; travel is counted in pulses.
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        ms_r    <= '0;
        dwell_r <= '0;
        trav_r  <= '0;
      end
      else
      begin
        if (st_r != ST_DWELL)
        begin
          ms_r    <= '0;
          dwell_r <= '0;
        end
        else if (ms_r == MS_LAST)
        begin
          ms_r    <= '0;
          dwell_r <= dwell_r + SPW'(1);
        end
        else
          ms_r <= ms_r + MSW'(1);
        if (st_r != ST_TRAVEL)
          trav_r <= '0;
        else if (pulse_r)
          trav_r <= trav_r + PW'(1);
      end
    end

    // Monitors; no earlier address is consulted, the home address is imposed at the stop.
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        cur_r  <= RST_ADDR;
        mach_r <= RST_ADDR;
        habs_r <= RST_ADDR;
      end
      else if (st_r == ST_DONE)
      begin
        cur_r  <= cfg_r.home_addr;
        mach_r <= cfg_r.home_addr;
        habs_r <= cfg_r.home_addr;
      end
      else if (wr && idle && offs == REG_CUR_FEED)
      begin
        cur_r  <= pwdata;
        habs_r <= habs_r + pwdata - cur_r;
      end
      else if (pulse_r)
      begin
        cur_r  <= cfg_r.dir_neg ? cur_r - PW'(1) : cur_r + PW'(1);
        mach_r <= cfg_r.dir_neg ? mach_r - PW'(1) : mach_r + PW'(1);
      end
    end

    // A request set in the same cycle as completion wins, so a lost drive is never masked.
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        req_r  <= RST_REQ;
        done_r <= 1'b0;
        rej_r  <= 1'b0;
      end
      else
      begin
        if (drdy_off || stn_rise)
          req_r <= 1'b1;
        else if (st_r == ST_DONE)
          req_r <= 1'b0;
        if (st_r == ST_DONE)
          done_r <= 1'b1;
        else if (start || drdy_off || stn_rise)
          done_r <= 1'b0;
        // Only the machine return is served; other kinds, bad methods or a busy axis are refused.
        if (ctrl_wr && !start)
          rej_r <= 1'b1;
        else if (start)
          rej_r <= 1'b0;
      end
    end

    always_comb
    begin
      rd_local = 32'h0000_0000;
      case (offs)
        REG_CFG:
        begin
          rd_local[CFG_METHOD_LSB +: 3] = cfg_r.method;
          rd_local[CFG_DIR_BIT]         = cfg_r.dir_neg;
        end
        REG_HOME_ADR: rd_local = cfg_r.home_addr;
        REG_HOME_SPD: rd_local[SPW-1:0] = cfg_r.home_spd;
        REG_CREEP:    rd_local[SPW-1:0] = cfg_r.creep_spd;
        REG_DWELL:    rd_local[SPW-1:0] = cfg_r.dwell_ms;
        REG_POST_DOG: rd_local = cfg_r.post_dog;
        REG_STATUS:
        begin
          rd_local[ST_REQ_BIT]          = req_r;
          rd_local[ST_DONE_BIT]         = done_r;
          rd_local[ST_BUSY_BIT]         = !idle;
          rd_local[ST_REJ_BIT]          = rej_r;
          rd_local[ST_STATE_LSB +: 3]   = st_r;
        end
        REG_CUR_FEED: rd_local = cur_r;
        REG_MACH:     rd_local = mach_r;
        REG_HOME_ABS: rd_local = habs_r;
        default:      rd_local = 32'h0000_0000;
      endcase
    end

    assign rd_word[a]    = rd_local;
    assign feed_pulse[a] = pulse_r;
    assign feed_dir[a]   = cfg_r.dir_neg;
    assign dev_clear[a]  = clr_r;
  end
endmodule

// ---- tb/ahrs_asserts.sv ----
// Port-level checks of the APB slave and the deviation clear sequence.
`timescale 1ns/1ps
module ahrs_asserts
  import ahrs_pkg::*;
(
  input wire logic            pclk,
  input wire logic            presetn,
  input wire logic            psel,
  input wire logic            penable,
  input wire logic            pwrite,
  input wire logic [AW-1:0]   paddr,
  input wire logic [31:0]     pwdata,
  input wire logic [31:0]     prdata,
  input wire logic            pready,
  input wire logic            pslverr,
  input wire logic [AXES-1:0] drive_ready,
  input wire logic            station_ready,
  input wire logic [AXES-1:0] near_dog,
  input wire logic [AXES-1:0] home_marker,
  input wire logic [AXES-1:0] feed_pulse,
  input wire logic [AXES-1:0] feed_dir,
  input wire logic [AXES-1:0] dev_clear
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic [10:0] clr_len_r;
  // Length of the current clear pulse, so its width can be judged when it ends.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      clr_len_r <= 11'h000;
    else if (dev_clear[0])
      clr_len_r <= clr_len_r + 11'h001;
    else
      clr_len_r <= 11'h000;
  end
  chk_ready_access: assert property (psel && penable |-> pready) else $error("no ready in access");
  chk_ready_one: assert property (pready |=> !pready) else $error("ready held too long");
  chk_err_zero: assert property (pslverr |-> pready && prdata == 32'h0000_0000) else $error("bad error answer");
  chk_clear_no_pulse: assert property (dev_clear[0] |-> !feed_pulse[0]) else $error("pulse in clear");
  chk_halt_first: assert property ($rose(dev_clear[0]) |-> !$past(feed_pulse[0])) else $error("clear too early");
  chk_clear_width: assert property ($fell(dev_clear[0]) |-> clr_len_r == 11'(DEVCLR_CYC - 1))
    else $error("clear width wrong");
  chk_quiet_after: assert property ($fell(dev_clear[0]) |-> !feed_pulse[0] [*2]) else $error("pulse after clear");
  chk_axis_b_clear: assert property (dev_clear[1] |-> !feed_pulse[1]) else $error("pulse in clear b");
  cover property ($rose(dev_clear[0]));
  cover property ($rose(dev_clear[1]));
  cover property (pslverr);
endmodule

// ---- tb/ahrs_axis_model.sv ----
// Behavioural servo drive and axis sensors: position count, near-point dog, marker and stopper.
`timescale 1ns/1ps
module ahrs_axis_model
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       feed_pulse,
  input  wire logic       arm,
  input  wire logic       stopper,
  input  wire logic [7:0] dog_lo,
  output logic            near_dog,
  output logic            home_marker,
  output logic [7:0]      pos
);
  logic mark_r;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pos <= 8'h00;
      mark_r <= 1'b0;
    end
    else if (arm)
      pos <= 8'h00;
    else
    begin
      // The motor stalls against the stopper, so pulses past it do not move the axis.
      if (feed_pulse && !(stopper && pos >= 8'h1C))
        pos <= pos + 8'h01;
      mark_r <= feed_pulse && pos[2:0] == 3'h7;
    end
  end
  assign near_dog = pos >= dog_lo && pos < dog_lo + 8'h08;
  assign home_marker = stopper ? pos >= 8'h1C : mark_r;
endmodule

// ---- tb/ahrs_tb_top.sv ----
// Self-checking bench: register traffic, all six homing methods and the request flag events.
`timescale 1ns/1ps
module ahrs_tb_top
  import ahrs_pkg::*;
;
  logic            pclk = 1'b0;
  logic            presetn = 1'b0;
  logic            psel = 1'b0;
  logic            penable = 1'b0;
  logic            pwrite = 1'b0;
  logic [AW-1:0]   paddr = 8'h00;
  logic [31:0]     pwdata = 32'h0000_0000;
  logic [31:0]     prdata;
  logic            pready;
  logic            pslverr;
  logic [AXES-1:0] drive_ready = 2'h3;
  logic            station_ready = 1'b0;
  logic [AXES-1:0] near_dog;
  logic [AXES-1:0] home_marker;
  logic [AXES-1:0] feed_pulse;
  logic [AXES-1:0] feed_dir;
  logic [AXES-1:0] dev_clear;
  logic [AXES-1:0] arm = 2'h0;
  logic [AXES-1:0] stopper = 2'h0;
  logic [7:0]      dog_lo [AXES] = '{8'h10, 8'h10};
  logic [7:0]      pos [AXES];
  logic [7:0]      exp_pos [6] = '{8'h20, 8'h00, 8'h1C, 8'h1C, 8'h18, 8'h15};
  logic [31:0]     rd;
  logic            err;
  int              clr_cnt [AXES] = '{0, 0};
  int              failures = 0;
  int              total_checks = 0;
  always #5 pclk = ~pclk;
  always @(posedge pclk)
    for (int a = 0; a < AXES; a++)
      if (dev_clear[a] === 1'b1)
        clr_cnt[a]++;
  ahrs_top #(.MS_CYCLES(10)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .drive_ready(drive_ready), .station_ready(station_ready), .near_dog(near_dog),
    .home_marker(home_marker), .feed_pulse(feed_pulse), .feed_dir(feed_dir), .dev_clear(dev_clear));
  for (genvar g = 0; g < AXES; g++)
  begin : g_ax
    ahrs_axis_model i_model (.pclk(pclk), .presetn(presetn), .feed_pulse(feed_pulse[g]), .arm(arm[g]),
      .stopper(stopper[g]), .dog_lo(dog_lo[g]), .near_dog(near_dog[g]), .home_marker(home_marker[g]),
      .pos(pos[g]));
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask
  // One APB transfer; the request stands until pready is sampled high.
  task automatic apb(input logic wr, input int ax, input logic [7:0] off, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= 8'(ax * 64) + off;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20)
    begin
      n++;
      @(posedge pclk);
    end
    if (pready !== 1'b1)
    begin
      failures++;
      print_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic run_home(input int ax, input ahrs_method_t m, input logic [31:0] ha, input logic [7:0] ep);
    int n;
    stopper[ax] <= m inside {M_STOP1, M_STOP2, M_STOP3};
    arm[ax] <= 1'b1;
    apb(1'b1, ax, 8'(REG_CFG), 32'(m) | (32'(m[0]) << CFG_DIR_BIT));
    arm[ax] <= 1'b0;
    check("direction", 32'(m[0]), 32'(feed_dir[ax]));
    apb(1'b1, ax, 8'(REG_HOME_SPD), 32'h0000_0004);
    apb(1'b1, ax, 8'(REG_CREEP), 32'h0000_0004);
    apb(1'b1, ax, 8'(REG_DWELL), 32'h0000_0002);
    apb(1'b1, ax, 8'(REG_POST_DOG), 32'h0000_0005);
    apb(1'b1, ax, 8'(REG_HOME_ADR), ha);
    apb(1'b1, ax, 8'(REG_CUR_FEED), 32'h0000_0077);
    clr_cnt[ax] = 0;
    apb(1'b1, ax, 8'(REG_CTRL), 32'(KIND_MACHINE) | (32'(m == M_DOG) << CTRL_RETRY_BIT));
    apb(1'b0, ax, 8'(REG_STATUS), 32'h0000_0000);
    check("busy", 32'h0000_0001, 32'(rd[ST_BUSY_BIT]));
    if (dog_lo[ax] == 8'h00)
      check("state on dog", 32'(ST_CREEP), 32'(rd[10:8]));
    n = 0;
    while (rd[ST_DONE_BIT] !== 1'b1 && n < 2000)
    begin
      apb(1'b0, ax, 8'(REG_STATUS), 32'h0000_0000);
      n++;
    end
    // A return that never completes is a mismatch and ends the run here.
    if (rd[ST_DONE_BIT] !== 1'b1)
    begin
      failures++;
      print_verdict();
    end
    // Position monitors are only trusted once the request flag has dropped.
    check("request", 32'h0000_0000, 32'(rd[ST_REQ_BIT]));
    check("reject", 32'h0000_0000, 32'(rd[ST_REJ_BIT]));
    check("clear cycles", m == M_CNT2 ? 0 : DEVCLR_CYC - 1, clr_cnt[ax]);
    if (ep != 8'h00)
      check("stop position", 32'(ep), 32'(pos[ax]));
    apb(1'b0, ax, 8'(REG_CUR_FEED), 32'h0000_0000);
    check("current feed", ha, rd);
    apb(1'b0, ax, 8'(REG_MACH), 32'h0000_0000);
    check("machine feed", ha, rd);
    apb(1'b0, ax, 8'(REG_HOME_ABS), 32'h0000_0000);
    check("home absolute", ha, rd);
  endtask
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 0, 8'(REG_STATUS), 32'h0000_0000);
    check("request at reset", 32'h0000_0001, 32'(rd[ST_REQ_BIT]));
    apb(1'b0, 1, 8'(REG_CREEP), 32'h0000_0000);
    check("creep reset", 32'(RST_CREEP), rd);
    apb(1'b0, 0, 8'h2C, 32'h0000_0000);
    check("unmapped", 32'h0000_0001, 32'(err));
    for (int k = 2; k < 4; k++)
    begin
      apb(1'b1, 0, 8'(REG_CTRL), 32'(k));
      apb(1'b0, 0, 8'(REG_STATUS), 32'h0000_0000);
      check("kind refused", 32'h0000_0001, 32'(rd[ST_REJ_BIT]));
    end
    // An undefined method code must refuse the start and leave the axis idle.
    apb(1'b1, 0, 8'(REG_CFG), 32'h0000_0006);
    apb(1'b1, 0, 8'(REG_CTRL), 32'(KIND_MACHINE));
    apb(1'b0, 0, 8'(REG_STATUS), 32'h0000_0000);
    check("method refused", 32'h0000_0009, 32'(rd[3:0]));
    for (int m = 0; m < 6; m++)
      run_home(0, ahrs_method_t'(m), 32'h0000_0100 + 32'(m), exp_pos[m]);
    apb(1'b1, 0, 8'(REG_CUR_FEED), 32'h0000_0108);
    apb(1'b0, 0, 8'(REG_HOME_ABS), 32'h0000_0000);
    check("home abs follows", 32'h0000_0108, rd);
    dog_lo[1] <= 8'h00;
    run_home(1, M_DOG, 32'h0000_0200, 8'h10);
    drive_ready[1] <= 1'b0;
    @(posedge pclk);
    apb(1'b0, 1, 8'(REG_STATUS), 32'h0000_0000);
    check("ready drop", 32'h0000_0001, 32'(rd[ST_REQ_BIT]));
    apb(1'b0, 0, 8'(REG_STATUS), 32'h0000_0000);
    check("other axis", 32'h0000_0000, 32'(rd[ST_REQ_BIT]));
    station_ready <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 0, 8'(REG_STATUS), 32'h0000_0000);
    check("station ready", 32'h0000_0001, 32'(rd[ST_REQ_BIT]));
    print_verdict();
  end
endmodule
bind ahrs_top ahrs_asserts i_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .drive_ready(drive_ready), .station_ready(station_ready), .near_dog(near_dog), .home_marker(home_marker),
  .feed_pulse(feed_pulse), .feed_dir(feed_dir), .dev_clear(dev_clear));
